// File: core_model.sv
// behavioural processor core answering overflow and edge requests
module core_model (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// answer control
	input wire logic ackOn,
	input wire logic [2:0] ackDelay,
	// requests from the timer block
	input wire logic [1:0] overflowFlag,
	input wire logic [1:0] extIrqReq,
	// vector acknowledges
	output logic [1:0] vecAckOvf,
	output logic [1:0] vecAckEdge
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] cnt_q;

	// vectors after a chosen delay, one-cycle acknowledge per pending request
	always_ff @(posedge clk) begin
		vecAckOvf <= 2'h0;
		vecAckEdge <= 2'h0;
		if (srst || !ackOn) begin
			cnt_q <= 3'h0;
		end else if ((overflowFlag | extIrqReq) != 2'h0) begin
			if (cnt_q >= ackDelay) begin
				vecAckOvf <= overflowFlag;
				vecAckEdge <= extIrqReq;
				cnt_q <= 3'h0;
			end else begin
				cnt_q <= cnt_q + 3'h1;
			end
		end
	end
endmodule // core_model

// File: dual_timer_counter.sv
// two timer/counters with four modes, apb register access
//
// Functional notes
// - mode 0: 8-bit high over low five bits
// - mode 0 rollover sets overflow flag
// - count only when run and (no gate or pin high)
// - setting run bit keeps count values
// - counter select: mode bit 6 b, 2 a
// - mode 1: 16-bit count, flag on wrap
// - mode 2: low reloads from high on overflow
// - timer b in mode 3 holds count
// - split mode: low a uses a's controls
// - split: high a counts ticks, b run/flag
// - split: b still counts, pulse, no flag
// - overflow flags set by hw, vector clears
// - run bits switch timers on and off
// - edge flags set on edge, ack clears
// - type bit: falling edge or low level
// - run/flag register resets to zero
// - toggle enable inverts count pin on overflow
// - spi enable bit held for serial unit
// - counter counts sampled high-then-low transitions
// - counting paced by shared prescaler tick
// - select clear counts ticks, set counts pin
// - mode bits: 13, 16, reload, split
//
// Design decision made here: the APB register port.
`include "timer_defines.svh"

module dual_timer_counter import timer_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// count pins, index 0 timer a, 1 timer b
	input wire logic [1:0] countPinIn,
	output logic [1:0] countPinOut,
	output logic [1:0] countPinOe,
	// external interrupt pins
	input wire logic [1:0] extIrqPin,
	// core vector acknowledges
	input wire logic [1:0] vecAckOvf,
	input wire logic [1:0] vecAckEdge,
	// to core and serial unit
	output logic [1:0] overflowFlag,
	output logic [1:0] extIrqReq,
	output logic [1:0] ovfPulse,
	output logic serialSpiEnable
);

	timer_state_t s_q;
	timer_state_t s_d;
	logic tick;
	logic [9:0] idx;
	logic wrAny;
	logic [1:0] pinFall;
	logic enA;
	logic enB;
	logic pulseA;
	logic pulseB;
	mode_t modeA;
	mode_t modeB;
	logic [16:0] stepA;
	logic [16:0] stepB;
	logic [16:0] stepHi;
	logic ovfA;
	logic ovfB;
	logic ovfHi;
	logic [1:0] setOvf;

	// ==========================================
	// helpers
	function automatic logic [16:0] stepCount(input mode_t m, input logic [7:0] lo, input logic [7:0] hi);
		logic [13:0] s13;
		logic [16:0] s16;
		logic [8:0] s8;
		s13 = {1'b0, hi, lo[4:0]} + 14'h0001;
		s16 = {1'b0, hi, lo} + 17'h00001;
		s8 = {1'b0, lo} + 9'h001;
		unique case (m)
			MODE_13BIT: stepCount = {s13[13], s13[12:5], lo[7:5], s13[4:0]};
			MODE_16BIT: stepCount = s16;
			MODE_RELOAD8: stepCount = {s8[8], hi, s8[8] ? hi : s8[7:0]};
			MODE_SPLIT: stepCount = {s8[8], hi, s8[7:0]};
		endcase
	endfunction

	function automatic logic isMapped(input logic [9:0] i);
		isMapped = (i == `RUN_FLAGS_IDX) || (i == `MODE_REG_IDX) || (i == `LOW_A_IDX) ||
			(i == `LOW_B_IDX) || (i == `HIGH_A_IDX) || (i == `HIGH_B_IDX) ||
			(i == `TOGGLE_CTRL_IDX) || (i == `PRESCALE_IDX);
	endfunction

	// ==========================================
	// shared rate tick
	timer_prescaler u_prescaler (
		.clk(clk),
		.srst(srst),
		.sharedPrescaleValue(s_q.prescale),
		.tick(tick)
	);

	// ==========================================
	// apb decode, zero wait states
	assign idx = paddr[11:2];
	assign wrAny = psel & penable & pwrite & pstrb[0] & isMapped(idx);
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~isMapped(idx);
	assign prdata = {24'h000000, s_q.rdData};

	// ==========================================
	// count sources and enables
	assign modeA = mode_t'(s_q.modeReg[`MODE_A_LSB +: 2]);
	assign modeB = mode_t'(s_q.modeReg[`MODE_B_LSB +: 2]);
	assign pinFall = tick ? (s_q.pinSample & ~s_q.pinSync) : 2'b00;
	assign pulseA = s_q.modeReg[`CNT_SEL_A_BIT] ? pinFall[0] : tick;
	assign pulseB = s_q.modeReg[`CNT_SEL_B_BIT] ? pinFall[1] : tick;
	assign enA = s_q.runFlags[`RUN_BIT_A_BIT] & (~s_q.modeReg[`GATE_A_BIT] | s_q.irqSync[0]);
	assign enB = s_q.runFlags[`RUN_BIT_B_BIT] & (~s_q.modeReg[`GATE_B_BIT] | s_q.irqSync[1]);
	assign stepA = stepCount(modeA, s_q.lowA, s_q.highA);
	assign stepB = stepCount(modeB, s_q.lowB, s_q.highB);
	assign stepHi = stepCount(MODE_SPLIT, s_q.highA, 8'h00);

	// overflow events
	assign ovfA = enA & pulseA & stepA[16];
	assign ovfB = enB & pulseB & (modeB != MODE_SPLIT) & stepB[16];
	// carry of the high byte stepped as a plain 8-bit counter
	assign ovfHi = (modeA == MODE_SPLIT) & s_q.runFlags[`RUN_BIT_B_BIT] & tick & stepHi[16];
	assign setOvf[0] = ovfA;
	assign setOvf[1] = (modeA == MODE_SPLIT) ? ovfHi : ovfB;

	// ==========================================
	// next state
	always_comb begin
		s_d = s_q;
		s_d.ovfPulse = {ovfB, ovfA};
		// pin synchronisers and tick-paced sampling
		s_d.pinMeta = countPinIn;
		s_d.pinSync = s_q.pinMeta;
		s_d.irqMeta = extIrqPin;
		s_d.irqSync = s_q.irqMeta;
		s_d.irqPrev = s_q.irqSync;
		if (tick) begin
			s_d.pinSample = s_q.pinSync;
		end
		// timer a
		if (enA && pulseA) begin
			s_d.lowA = stepA[7:0];
			if (modeA != MODE_SPLIT) begin
				s_d.highA = stepA[15:8];
			end
		end
		// split mode high byte
		if ((modeA == MODE_SPLIT) && s_q.runFlags[`RUN_BIT_B_BIT] && tick) begin
			s_d.highA = stepHi[7:0];
		end
		// timer b, frozen in its own mode 3
		if (enB && pulseB && (modeB != MODE_SPLIT)) begin
			s_d.lowB = stepB[7:0];
			s_d.highB = stepB[15:8];
		end
		// pin toggle on overflow
		if (ovfA && s_q.toggleCtrl[1]) begin
			s_d.toggleOut[0] = ~s_q.toggleOut[0];
		end
		if (ovfB && s_q.toggleCtrl[2]) begin
			s_d.toggleOut[1] = ~s_q.toggleOut[1];
		end
		// software writes; counters keep value on run set
		if (wrAny) begin
			case (idx)
				`RUN_FLAGS_IDX: s_d.runFlags = pwdata[7:0];
				`MODE_REG_IDX: s_d.modeReg = pwdata[7:0];
				`LOW_A_IDX: s_d.lowA = pwdata[7:0];
				`LOW_B_IDX: s_d.lowB = pwdata[7:0];
				`HIGH_A_IDX: s_d.highA = pwdata[7:0];
				`HIGH_B_IDX: s_d.highB = pwdata[7:0];
				`TOGGLE_CTRL_IDX: s_d.toggleCtrl = pwdata[7:5];
				`PRESCALE_IDX: s_d.prescale = pwdata[3:0];
				default: ;
			endcase
		end
		// vector acknowledges clear flags
		if (vecAckOvf[0]) begin
			s_d.runFlags[`OVF_FLAG_A_BIT] = 1'b0;
		end
		if (vecAckOvf[1]) begin
			s_d.runFlags[`OVF_FLAG_B_BIT] = 1'b0;
		end
		if (vecAckEdge[0]) begin
			s_d.runFlags[`EDGE_FLAG_A_BIT] = 1'b0;
		end
		if (vecAckEdge[1]) begin
			s_d.runFlags[`EDGE_FLAG_B_BIT] = 1'b0;
		end
		// hardware sets win over any clear
		if (setOvf[0]) begin
			s_d.runFlags[`OVF_FLAG_A_BIT] = 1'b1;
		end
		if (setOvf[1]) begin
			s_d.runFlags[`OVF_FLAG_B_BIT] = 1'b1;
		end
		if (s_q.runFlags[`TRIG_TYPE_A_BIT] && s_q.irqPrev[0] && !s_q.irqSync[0]) begin
			s_d.runFlags[`EDGE_FLAG_A_BIT] = 1'b1;
		end
		if (s_q.runFlags[`TRIG_TYPE_B_BIT] && s_q.irqPrev[1] && !s_q.irqSync[1]) begin
			s_d.runFlags[`EDGE_FLAG_B_BIT] = 1'b1;
		end
		// read data captured in setup phase
		if (psel && !penable) begin
			case (idx)
				`RUN_FLAGS_IDX: s_d.rdData = s_q.runFlags;
				`MODE_REG_IDX: s_d.rdData = s_q.modeReg;
				`LOW_A_IDX: s_d.rdData = s_q.lowA;
				`LOW_B_IDX: s_d.rdData = s_q.lowB;
				`HIGH_A_IDX: s_d.rdData = s_q.highA;
				`HIGH_B_IDX: s_d.rdData = s_q.highB;
				`TOGGLE_CTRL_IDX: s_d.rdData = {s_q.toggleCtrl, 5'h00};
				`PRESCALE_IDX: s_d.rdData = {4'h0, s_q.prescale};
				default: s_d.rdData = 8'h00;
			endcase
		end
	end

	// state register
	always_ff @(posedge clk) begin
		if (srst) begin
			s_q <= '0;
			s_q.runFlags <= `RUN_FLAGS_RST;
			s_q.modeReg <= `MODE_REG_RST;
			s_q.toggleCtrl <= `TOGGLE_CTRL_RST;
			s_q.prescale <= `PRESCALE_RST;
		end else begin
			s_q <= s_d;
		end
	end

	// ==========================================
	// outputs
	assign countPinOut = s_q.toggleOut;
	assign countPinOe = s_q.toggleCtrl[2:1];
	assign overflowFlag = {s_q.runFlags[`OVF_FLAG_B_BIT], s_q.runFlags[`OVF_FLAG_A_BIT]};
	assign ovfPulse = s_q.ovfPulse;
	assign serialSpiEnable = s_q.toggleCtrl[0];
	// level mode requests while pin low
	assign extIrqReq[0] = s_q.runFlags[`TRIG_TYPE_A_BIT] ? s_q.runFlags[`EDGE_FLAG_A_BIT] : ~s_q.irqSync[0];
	assign extIrqReq[1] = s_q.runFlags[`TRIG_TYPE_B_BIT] ? s_q.runFlags[`EDGE_FLAG_B_BIT] : ~s_q.irqSync[1];

	// ==========================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	property p_resetFlags;
		$past(srst) |-> (s_q.runFlags == 8'h00);
	endproperty
	a_resetFlags: assert property (p_resetFlags) else $error("run/flag register not zero after reset");

	property p_ovfFlagA;
		s_q.ovfPulse[0] |-> s_q.runFlags[`OVF_FLAG_A_BIT];
	endproperty
	a_ovfFlagA: assert property (p_ovfFlagA) else $error("timer a overflow did not set its flag");

	property p_setWins;
		setOvf[0] && wrAny |=> s_q.runFlags[`OVF_FLAG_A_BIT];
	endproperty
	a_setWins: assert property (p_setWins) else $error("overflow lost against software write");

	property p_stopA;
		!s_q.runFlags[`RUN_BIT_A_BIT] && !wrAny |=> $stable(s_q.lowA);
	endproperty
	a_stopA: assert property (p_stopA) else $error("timer a low byte moved while stopped");

	property p_stopB;
		!s_q.runFlags[`RUN_BIT_B_BIT] && !wrAny |=> $stable(s_q.lowB) && $stable(s_q.highB);
	endproperty
	a_stopB: assert property (p_stopB) else $error("timer b moved while run bit clear");

	property p_freezeB;
		(modeB == MODE_SPLIT) && !wrAny |=> $stable(s_q.lowB) && $stable(s_q.highB);
	endproperty
	a_freezeB: assert property (p_freezeB) else $error("timer b counted in its mode 3");

	property p_reload;
		(modeA == MODE_RELOAD8) && s_q.ovfPulse[0] && !$past(wrAny) |-> (s_q.lowA == s_q.highA);
	endproperty
	a_reload: assert property (p_reload) else $error("reload value not loaded on overflow");

	property p_tickPace;
		!$past(tick) && !$past(wrAny) |-> $stable(s_q.lowA);
	endproperty
	a_tickPace: assert property (p_tickPace) else $error("timer a advanced without prescaler tick");

	property p_toggleB;
		s_q.ovfPulse[1] && $past(s_q.toggleCtrl[2]) |-> (s_q.toggleOut[1] != $past(s_q.toggleOut[1]));
	endproperty
	a_toggleB: assert property (p_toggleB) else $error("timer b pin did not toggle");

endmodule // dual_timer_counter

// File: dual_timer_counter_modes_bench.sv
// self-checking bench for the dual timer/counter block
`include "timer_defines.svh"

module dual_timer_counter_modes_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, ackOn = 1;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata;
	logic [3:0] pstrb = 4'hf;
	logic pready, pslverr, serialSpiEnable;
	logic [1:0] countPinIn = 2'h3, extIrqPin = 2'h3, vecAckOvf, vecAckEdge;
	logic [1:0] countPinOut, countPinOe, overflowFlag, extIrqReq, ovfPulse;
	logic [2:0] ackDelay = 3'h0;
	logic [32:0] q[$];
	logic [7:0] r, ps;
	int fails = 0, checkCount = 0, nEdges;

	// ==========================================
	// design, core model, clock
	dual_timer_counter DUT (.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.countPinIn(countPinIn), .countPinOut(countPinOut), .countPinOe(countPinOe), .extIrqPin(extIrqPin),
		.vecAckOvf(vecAckOvf), .vecAckEdge(vecAckEdge), .overflowFlag(overflowFlag), .extIrqReq(extIrqReq),
		.ovfPulse(ovfPulse), .serialSpiEnable(serialSpiEnable));
	core_model core (.clk(clk), .srst(srst), .ackOn(ackOn), .ackDelay(ackDelay), .overflowFlag(overflowFlag),
		.extIrqReq(extIrqReq), .vecAckOvf(vecAckOvf), .vecAckEdge(vecAckEdge));
	initial begin
		forever #5 clk = ~clk;
	end

	// ==========================================
	// compare, verdict
	task automatic check(input logic [32:0] seen, input logic [32:0] exp);
		checkCount++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task results;
		$display("checks %0d fails %0d", checkCount, fails);
		if (fails == 0 && checkCount > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// read results are matched against the oldest queued note
	always @(posedge clk) begin
		if (psel && penable && pready && !pwrite) begin
			if (q.size() > 0) begin
				check({pslverr, prdata}, q.pop_front());
			end else begin
				check(33'h0, 33'h1);
			end
		end
	end

	// ==========================================
	// apb master tasks
	task apb(input logic w, input logic [9:0] i, input logic [7:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {i, 2'b00};
		pwdata <= {24'h0, d};
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task rd(input logic [9:0] i, input logic [32:0] e);
		q.push_back(e);
		apb(1'b0, i, 8'h00);
	endtask

	// stop timer a, load it and start it again
	task start(input logic [7:0] md, input logic [7:0] lo, input logic [7:0] hi, input logic [7:0] pv);
		apb(1'b1, `RUN_FLAGS_IDX, 8'h00);
		apb(1'b1, `LOW_A_IDX, lo);
		apb(1'b1, `HIGH_A_IDX, hi);
		apb(1'b1, `MODE_REG_IDX, md);
		apb(1'b1, `PRESCALE_IDX, pv);
		apb(1'b1, `RUN_FLAGS_IDX, 8'h10);
	endtask

	// cycles between two overflow pulses, pin toggled at each
	task period(input int i, input int e);
		int n;
		logic t;
		n = 0;
		do begin @(negedge clk); n++; end while (ovfPulse[i] !== 1'b1 && n < 90000);
		t = countPinOut[i];
		n = 0;
		do begin @(negedge clk); n++; end while (ovfPulse[i] !== 1'b1 && n < 90000);
		check(33'(n), 33'(e));
		check({32'h0, countPinOut[i]}, {32'h0, ~t});
	endtask

	// ==========================================
	// watchdog
	initial begin
		repeat (100000) @(posedge clk);
		fails++;
		results;
	end

	// ==========================================
	// main sequence
	initial begin
		void'($urandom(86418));
		repeat (10) @(posedge clk);
		srst <= 1'b0;
		rd(`RUN_FLAGS_IDX, 33'h0);
		rd(`MODE_REG_IDX, 33'h0);
		rd(10'h0a0, {1'b1, 32'h0});
		r = 8'($urandom);
		apb(1'b1, `HIGH_B_IDX, r);
		rd(`HIGH_B_IDX, {25'h0, r});
		// counter mode: falling pin edges counted
		nEdges = $urandom_range(1, 20);
		start(8'h06, 8'h00, 8'h00, 8'h00);
		repeat (nEdges) begin
			@(posedge clk) countPinIn[0] <= 1'b0;
			repeat (3) @(posedge clk);
			countPinIn[0] <= 1'b1;
			repeat (3) @(posedge clk);
		end
		repeat (6) @(posedge clk);
		apb(1'b1, `RUN_FLAGS_IDX, 8'h00);
		rd(`LOW_A_IDX, 33'(nEdges));
		// toggle outputs and serial enable
		apb(1'b1, `TOGGLE_CTRL_IDX, 8'he0);
		rd(`TOGGLE_CTRL_IDX, 33'he0);
		check({31'h0, countPinOe}, 33'h3);
		check({32'h0, serialSpiEnable}, 33'h1);
		// periods of reload, 13-bit and 16-bit modes
		r = 8'($urandom);
		ps = 8'($urandom_range(0, 15));
		start(8'h02, 8'hff, r, ps);
		period(0, (256 - int'(r)) * (int'(ps) + 1));
		start(8'h00, 8'h1f, 8'hff, 8'h00);
		period(0, 8192);
		start(8'h01, 8'hff, 8'hff, 8'h00);
		period(0, 65536);
		// gated timer holds while the pin is low
		start(8'h00, 8'h00, 8'h00, 8'h00);
		extIrqPin[0] <= 1'b0;
		apb(1'b1, `MODE_REG_IDX, 8'h09);
		apb(1'b1, `LOW_A_IDX, 8'h07);
		repeat (10) @(posedge clk);
		rd(`LOW_A_IDX, 33'h7);
		// timer b in mode 3 holds its count
		apb(1'b1, `MODE_REG_IDX, 8'h30);
		apb(1'b1, `LOW_B_IDX, 8'h05);
		apb(1'b1, `RUN_FLAGS_IDX, 8'h40);
		repeat (10) @(posedge clk);
		rd(`LOW_B_IDX, 33'h5);
		// split mode: high byte of a runs on b's run bit, flags b
		ackOn <= 1'b0;
		apb(1'b1, `HIGH_A_IDX, 8'hf8);
		apb(1'b1, `MODE_REG_IDX, 8'h03);
		repeat (20) @(negedge clk);
		check({31'h0, overflowFlag}, 33'h2);
		apb(1'b1, `RUN_FLAGS_IDX, 8'h00);
		ackDelay <= 3'($urandom);
		ackOn <= 1'b1;
		repeat (16) @(negedge clk);
		check({31'h0, overflowFlag}, 33'h0);
		// falling-edge request on interrupt pin a
		ackOn <= 1'b0;
		extIrqPin[0] <= 1'b1;
		apb(1'b1, `RUN_FLAGS_IDX, 8'h01);
		repeat (4) @(posedge clk);
		extIrqPin[0] <= 1'b0;
		repeat (6) @(posedge clk);
		rd(`RUN_FLAGS_IDX, 33'h3);
		ackOn <= 1'b1;
		repeat (16) @(negedge clk);
		check({32'h0, extIrqReq[0]}, 33'h0);
		// timer b in reload mode, pin b toggled
		apb(1'b1, `MODE_REG_IDX, 8'h20);
		apb(1'b1, `LOW_B_IDX, 8'hff);
		apb(1'b1, `HIGH_B_IDX, r);
		apb(1'b1, `RUN_FLAGS_IDX, 8'h40);
		period(1, 256 - int'(r));
		results;
	end
endmodule // dual_timer_counter_modes_bench

// File: timer_defines.svh
// constants for the dual timer/counter block
`ifndef TIMER_DEFINES_SVH
`define TIMER_DEFINES_SVH

// ==========================================
// register indexes (byte address = index * 4)
`define RUN_FLAGS_IDX 10'h088
`define MODE_REG_IDX 10'h089
`define LOW_A_IDX 10'h08a
`define LOW_B_IDX 10'h08b
`define HIGH_A_IDX 10'h08c
`define HIGH_B_IDX 10'h08d
`define TOGGLE_CTRL_IDX 10'h091
`define PRESCALE_IDX 10'h092

// ==========================================
// run/flag register fields
`define OVF_FLAG_B_BIT 7
`define RUN_BIT_B_BIT 6
`define OVF_FLAG_A_BIT 5
`define RUN_BIT_A_BIT 4
`define EDGE_FLAG_B_BIT 3
`define TRIG_TYPE_B_BIT 2
`define EDGE_FLAG_A_BIT 1
`define TRIG_TYPE_A_BIT 0

// ==========================================
// mode register fields
`define GATE_B_BIT 7
`define CNT_SEL_B_BIT 6
`define MODE_B_LSB 4
`define GATE_A_BIT 3
`define CNT_SEL_A_BIT 2
`define MODE_A_LSB 0

// ==========================================
// toggle control fields (held in bits 7..5)
`define TOGGLE_EN_B_BIT 7
`define TOGGLE_EN_A_BIT 6
`define SPI_EN_BIT 5

// ==========================================
// reset values
`define RUN_FLAGS_RST 8'h00
`define MODE_REG_RST 8'h00
`define TOGGLE_CTRL_RST 3'h0
`define PRESCALE_RST 4'h0

`endif

// File: timer_pkg.sv
// types shared by the dual timer/counter block
package timer_pkg;

	// ==========================================
	// operating modes, in mode-bit order
	typedef enum logic [1:0] {
		MODE_13BIT,
		MODE_16BIT,
		MODE_RELOAD8,
		MODE_SPLIT
	} mode_t;

	// ==========================================
	// prescaler state
	typedef struct packed {
		logic [3:0] count;
		logic tick;
	} prescale_state_t;

	// ==========================================
	// timer block state; index 0 is timer a, 1 is timer b
	typedef struct packed {
		logic [7:0] runFlags;
		logic [7:0] modeReg;
		logic [7:0] lowA;
		logic [7:0] lowB;
		logic [7:0] highA;
		logic [7:0] highB;
		logic [2:0] toggleCtrl;
		logic [3:0] prescale;
		logic [1:0] pinMeta;
		logic [1:0] pinSync;
		logic [1:0] pinSample;
		logic [1:0] irqMeta;
		logic [1:0] irqSync;
		logic [1:0] irqPrev;
		logic [1:0] toggleOut;
		logic [1:0] ovfPulse;
		logic [7:0] rdData;
	} timer_state_t;

endpackage

// File: timer_prescaler.sv
// shared count-rate prescaler, one tick every (value + 1) clocks
module timer_prescaler import timer_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic srst,
	// divide value
	input wire logic [3:0] sharedPrescaleValue,
	// rate tick
	output logic tick
);

	prescale_state_t s_q;
	prescale_state_t s_d;

	// ==========================================
	// divider
	always_comb begin
		s_d = s_q;
		if (s_q.count >= sharedPrescaleValue) begin
			s_d.count = 4'h0;
			s_d.tick = 1'b1;
		end else begin
			s_d.count = s_q.count + 4'h1;
			s_d.tick = 1'b0;
		end
	end

	// state register
	always_ff @(posedge clk) begin
		if (srst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign tick = s_q.tick;

endmodule // timer_prescaler
